/* File: rtl/fibc_consts.vh */
`ifndef FIBC_CONSTS_VH
`define FIBC_CONSTS_VH
// ************************************************************
// register offsets (memory mapped, core data space)
// ************************************************************
`define FIBC_ADDR_WRDATA     8'hA0
`define FIBC_ADDR_PULSE      8'hA1
`define FIBC_ADDR_KEY        8'hA2
`define FIBC_ADDR_OPTION     8'hA3
// ************************************************************
// reset values and field layout
// ************************************************************
`define FIBC_PULSE_RST       8'h7B
`define FIBC_PULSE_WMASK     8'h7F
`define FIBC_WRDATA_RST      8'h00
`define FIBC_KEY_PATTERN     6'h26
`define FIBC_KEY_HI          7
`define FIBC_KEY_LO          2
`define FIBC_OPT_FLEX        0
`define FIBC_OPT_SEC         1
// ************************************************************
// timing
// ************************************************************
`define FIBC_KEY_CYCLES      4'h8
`define FIBC_HV_DEBOUNCE     4'hF
`define FIBC_PC_ZERO         16'h0000
`endif

/* File: rtl/fibc_flash_isp_boot_control.v */
// Functional notes
// - flash write/erase pulse width derives from pulse_width_setting value.
// - pulse code chosen from frequency band table, 25 kHz up to 10 MHz.
// - reset loads pulse_width_setting with the 10 MHz band code.
// - key write with upper six bits matching sets unlock flag; low bits ignored.
// - unlock flag stays set exactly eight instruction cycles, then clears.
// - jump-to-boot enters boot ROM only while unlock flag is set.
// - mismatched key leaves flag clear; jump goes to flash target.
// - return-to-flash moves execution from boot ROM to flash.
// - in emulation, breakpoint freezes unlock window counter.
// - unlock window keeps counting during interrupts.
// - forced-boot high voltage at reset ignores flex bit, starts boot ROM 0000.
// - later ordinary reset with flex set starts flash at 0000.
// - forced boot never modifies flex or security bits.
// - security bit cleared only by mass erase or user routine.
// - during high voltage, load clock drives serial clock pin; pin reads 1.
// - boot waits for forced-boot pin low and debounced before serial ISP.
// - normal reset: flex 0 starts boot ROM, flex 1 starts flash 0000.
`timescale 1ns/1ns
`include "fibc_consts.vh"
module fibc_flash_isp_boot_control #(
	parameter PULSE_UNIT = 16
) (
	// clock and reset
	input  wire        clk,
	input  wire        rst_n,
	// core data bus
	input  wire [7:0]  busAddr,
	input  wire        busWrite,
	input  wire        busRead,
	input  wire [7:0]  busWdata,
	output reg  [7:0]  busRdata,
	// core instruction timing and control flow
	input  wire        instrCycle,
	input  wire        breakActive,
	input  wire        emulMode,
	input  wire        jumpToBootInstr,
	input  wire        returnToFlashInstr,
	output reg         execBootRom,
	output reg         bootGranted,
	// flash operation control
	input  wire        flashOpStart,
	input  wire        massEraseDone,
	input  wire        userClearSec,
	input  wire        optFlexIn,
	input  wire        optSecIn,
	output reg         flashPulse,
	output reg         flashOpBusy,
	output reg  [7:0]  writeDataOut,
	output reg         secBit,
	// forced boot pins
	input  wire        forcedBootHv,
	input  wire        forcedBootPin,
	input  wire        loadClock,
	output reg         serialClockPinOut,
	output reg         serialClockPinOe,
	output reg         forcedBootRead,
	output reg         serialIspEnable
);
	// ************************************************************
	// input synchronisers
	// ************************************************************
	reg [1:0] hvSync_r;
	reg [1:0] pinSync_r;
	reg [1:0] lclkSync_r;
	// the detector chain has no reset: it must fill while reset is held,
	// otherwise the first edge after release would always see zero
	always @(posedge clk) begin
		hvSync_r <= {hvSync_r[0], forcedBootHv};
	end
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pinSync_r  <= 2'h0;
			lclkSync_r <= 2'h0;
		end else begin
			pinSync_r  <= {pinSync_r[0], forcedBootPin};
			lclkSync_r <= {lclkSync_r[0], loadClock};
		end
	end
	wire hvNow = hvSync_r[1];

	// ************************************************************
	// reset-exit boot selection
	// ************************************************************
	// the detector is caught on the first edge after release; the host holds
	// the voltage from three cycles before release so the sample is stable
	reg started_r;
	reg forcedBoot_r;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			started_r    <= 1'b0;
			forcedBoot_r <= 1'b0;
		end else if (!started_r) begin
			started_r    <= 1'b1;
			forcedBoot_r <= hvNow;
		end
	end

	// ************************************************************
	// registers
	// ************************************************************
	reg [7:0] pulseSet_r;
	reg [7:0] wrData_r;
	wire wrPulse  = busWrite && busAddr == `FIBC_ADDR_PULSE;
	wire wrData   = busWrite && busAddr == `FIBC_ADDR_WRDATA;
	wire wrKey    = busWrite && busAddr == `FIBC_ADDR_KEY;
	wire keyMatch = busWdata[`FIBC_KEY_HI:`FIBC_KEY_LO] == `FIBC_KEY_PATTERN;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pulseSet_r <= `FIBC_PULSE_RST;
			wrData_r   <= `FIBC_WRDATA_RST;
		end else begin
			// bit 7 is read-only; writes during an operation are dropped
			if (wrPulse && !flashOpBusy) begin
				pulseSet_r <= busWdata & `FIBC_PULSE_WMASK;
			end
			if (wrData && !flashOpBusy) begin
				wrData_r <= busWdata;
			end
		end
	end

	// ************************************************************
	// unlock window
	// ************************************************************
	reg       keyFlag_r;
	reg [3:0] keyCnt_r;
	wire      keyFrozen = emulMode && breakActive;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			keyFlag_r <= 1'b0;
			keyCnt_r  <= 4'h0;
		end else if (wrKey) begin
			keyFlag_r <= keyMatch;
			keyCnt_r  <= keyMatch ? `FIBC_KEY_CYCLES : 4'h0;
		end else if (keyFlag_r && instrCycle && !keyFrozen) begin
			// interrupts do not stop this count
			keyCnt_r <= keyCnt_r - 4'h1;
			if (keyCnt_r == 4'h1) begin
				keyFlag_r <= 1'b0;
			end
		end
	end

	// ************************************************************
	// execution space selection
	// ************************************************************
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			execBootRom <= 1'b0;
			bootGranted <= 1'b0;
		end else if (!started_r) begin
			// both paths start at address 0000 of the chosen space
			execBootRom <= hvNow | ~optFlexIn;
			bootGranted <= 1'b0;
		end else begin
			bootGranted <= jumpToBootInstr && keyFlag_r;
			if (jumpToBootInstr && keyFlag_r) begin
				execBootRom <= 1'b1;
			end else if (returnToFlashInstr) begin
				execBootRom <= 1'b0;
			end
		end
	end

	// ************************************************************
	// option bits
	// ************************************************************
	// option bits are only read here; forced boot never writes them
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			secBit <= 1'b0;
		end else if (!started_r) begin
			secBit <= optSecIn;
		end else if (massEraseDone || userClearSec) begin
			secBit <= 1'b0;
		end
	end

	// ************************************************************
	// flash pulse timer
	// ************************************************************
	reg [15:0] pulseCnt_r;
	localparam [15:0] PULSE_UNIT_W = PULSE_UNIT;
	wire [15:0] pulseLen = pulseSet_r * PULSE_UNIT_W[7:0];
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pulseCnt_r   <= 16'h0000;
			flashPulse   <= 1'b0;
			flashOpBusy  <= 1'b0;
			writeDataOut <= `FIBC_WRDATA_RST;
		end else if (flashOpStart && !flashOpBusy) begin
			pulseCnt_r   <= pulseLen;
			flashPulse   <= 1'b1;
			flashOpBusy  <= 1'b1;
			writeDataOut <= wrData_r;
		end else if (flashOpBusy) begin
			if (pulseCnt_r <= 16'h0001) begin
				flashPulse  <= 1'b0;
				flashOpBusy <= 1'b0;
			end else begin
				pulseCnt_r <= pulseCnt_r - 16'h0001;
			end
		end
	end

	// ************************************************************
	// forced boot pins and debounce
	// ************************************************************
	reg [3:0] dbCnt_r;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			serialClockPinOut <= 1'b0;
			serialClockPinOe  <= 1'b0;
			forcedBootRead    <= 1'b0;
			serialIspEnable   <= 1'b0;
			dbCnt_r           <= 4'h0;
		end else begin
			serialClockPinOut <= hvNow & lclkSync_r[1];
			serialClockPinOe  <= hvNow;
			forcedBootRead    <= hvNow | pinSync_r[1];
			if (!forcedBoot_r || serialIspEnable) begin
				dbCnt_r <= 4'h0;
			end else if (hvNow || pinSync_r[1]) begin
				dbCnt_r <= 4'h0;
			end else if (dbCnt_r == `FIBC_HV_DEBOUNCE) begin
				serialIspEnable <= 1'b1;
			end else begin
				dbCnt_r <= dbCnt_r + 4'h1;
			end
		end
	end

	// ************************************************************
	// read mux
	// ************************************************************
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busRdata <= 8'h00;
		end else if (busRead) begin
			case (busAddr)
				`FIBC_ADDR_WRDATA: busRdata <= wrData_r;
				`FIBC_ADDR_PULSE:  busRdata <= pulseSet_r;
				`FIBC_ADDR_OPTION: busRdata <= {6'h00, secBit, optFlexIn};
				default:           busRdata <= 8'h00;
			endcase
		end
	end
endmodule // fibc_flash_isp_boot_control

/* File: sim/fibc_checker.sv */
`timescale 1ns/1ns
// ****
// port checks
// ****
module fibc_checker (
	// watched ports
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic       jumpToBootInstr,
	input wire logic       returnToFlashInstr,
	input wire logic       execBootRom,
	input wire logic       bootGranted,
	input wire logic       flashOpStart,
	input wire logic       flashPulse,
	input wire logic       flashOpBusy,
	input wire logic [7:0] writeDataOut,
	input wire logic       secBit,
	input wire logic       massEraseDone,
	input wire logic       userClearSec,
	input wire logic       forcedBootHv,
	input wire logic       serialClockPinOe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_grant_needs_jump: assert property (
		bootGranted |-> $past(jumpToBootInstr) && execBootRom) else $error("stray grant");
	a_return_to_flash: assert property (
		returnToFlashInstr |=> !execBootRom) else $error("return ignored");
	a_pulse_start: assert property (
		$rose(flashPulse) |-> $past(flashOpStart)) else $error("stray pulse");
	a_pulse_in_op: assert property (
		flashPulse |-> flashOpBusy) else $error("pulse outside op");
	a_data_held: assert property (
		flashOpBusy && $past(flashOpBusy) |-> $stable(writeDataOut)) else $error("data moved");
	a_sec_clear: assert property (
		$fell(secBit) |-> $past(massEraseDone || userClearSec)) else $error("sec lost");
	a_hv_drive_on: assert property (
		forcedBootHv [*6] |=> serialClockPinOe) else $error("no load clock");
	a_hv_drive_off: assert property (
		!forcedBootHv [*6] |=> !serialClockPinOe) else $error("pin driven");
endmodule // fibc_checker

/* File: sim/fibc_flash_isp_boot_control_bench.sv */
`timescale 1ns/1ns
// ****
// bench
// ****
module fibc_flash_isp_boot_control_bench;
	logic       clk = 1'b0, benchRstN = 1'b0, busWrite = 1'b0, busRead = 1'b0;
	logic [7:0] busAddr = 8'h00, busWdata = 8'h00, busRdata, writeDataOut;
	logic       instrCycle = 1'b0, breakActive = 1'b0, emulMode = 1'b0;
	logic       jumpToBootInstr = 1'b0, returnToFlashInstr = 1'b0, flashOpStart = 1'b0;
	logic       massEraseDone = 1'b0, userClearSec = 1'b0, optFlexIn = 1'b1, optSecIn = 1'b1;
	logic       execBootRom, bootGranted, flashPulse, flashOpBusy, secBit;
	logic       serialClockPinOut, serialClockPinOe, forcedBootRead, serialIspEnable;
	logic       hostRstN, forcedBootHv, forcedBootPin, loadClock;
	wire        rst_n = benchRstN & hostRstN;
	int         n_errors = 0, cmp_count = 0, n;
	fibc_host_model host_u (.clk, .hostRstN, .forcedBootHv, .forcedBootPin, .loadClock);
	fibc_flash_isp_boot_control dut_u (.clk, .rst_n, .busAddr, .busWrite, .busRead,
		.busWdata, .busRdata, .instrCycle, .breakActive, .emulMode, .jumpToBootInstr,
		.returnToFlashInstr, .execBootRom, .bootGranted, .flashOpStart, .massEraseDone,
		.userClearSec, .optFlexIn, .optSecIn, .flashPulse, .flashOpBusy, .writeDataOut,
		.secBit, .forcedBootHv, .forcedBootPin, .loadClock, .serialClockPinOut,
		.serialClockPinOe, .forcedBootRead, .serialIspEnable);
	initial forever #5 clk = ~clk;
	task chk(input logic [7:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic pls(ref logic s, input int k);
		repeat (k) begin
			@(negedge clk);
			s = 1'b1;
			@(negedge clk);
			s = 1'b0;
		end
	endtask
	task wr(input logic [7:0] a, d);
		busAddr = a;
		busWdata = d;
		pls(busWrite, 1);
	endtask
	task rd(input logic [7:0] a, e);
		busAddr = a;
		pls(busRead, 1);
		@(negedge clk);
		chk(busRdata, e);
	endtask
	task jmp(input logic e);
		pls(jumpToBootInstr, 1);
		chk(bootGranted, e);
		@(negedge clk);
		chk(execBootRom, e);
		pls(returnToFlashInstr, 1);
		@(negedge clk);
		chk(execBootRom, 1'b0);
	endtask
	task t_regs;
		rd(8'hA1, 8'h7B);
		rd(8'hA0, 8'h00);
		rd(8'h5C, 8'h00);
		wr(8'hA1, 8'hFF);
		rd(8'hA1, 8'h7F);
		chk(execBootRom, 1'b0);
		$display("t_regs done");
	endtask
	task t_pulse;
		wr(8'hA1, 8'h02);
		wr(8'hA0, 8'h5A);
		pls(flashOpStart, 1);
		for (n = 0; flashPulse === 1'b1 && n < 99; n++) @(negedge clk);
		chk(n[7:0], 8'h20);
		wait (flashOpBusy === 1'b0);
		@(negedge clk);
		pls(flashOpStart, 1);
		wr(8'hA0, 8'hA5);
		wait (flashOpBusy === 1'b0);
		@(negedge clk);
		chk(writeDataOut, 8'h5A);
		$display("t_pulse done");
	endtask
	task t_key;
		wr(8'hA2, 8'h9B);
		pls(instrCycle, 7);
		jmp(1'b1);
		wr(8'hA2, 8'h98);
		pls(instrCycle, 8);
		jmp(1'b0);
		wr(8'hA2, 8'h9C);
		jmp(1'b0);
		emulMode = 1'b1;
		breakActive = 1'b1;
		wr(8'hA2, 8'h99);
		pls(instrCycle, 12);
		breakActive = 1'b0;
		jmp(1'b1);
		emulMode = 1'b0;
		$display("t_key done");
	endtask
	task t_forced;
		host_u.hv_on;
		repeat (6) @(negedge clk);
		chk(execBootRom, 1'b1);
		chk(serialClockPinOe, 1'b1);
		chk(forcedBootRead, 1'b1);
		chk(serialIspEnable, 1'b0);
		chk(secBit, 1'b1);
		host_u.hv_off;
		repeat (30) @(negedge clk);
		chk(serialIspEnable, 1'b1);
		benchRstN = 1'b0;
		repeat (10) @(negedge clk);
		benchRstN = 1'b1;
		repeat (2) @(negedge clk);
		chk(execBootRom, 1'b0);
		pls(massEraseDone, 1);
		@(negedge clk);
		chk(secBit, 1'b0);
		$display("t_forced done");
	endtask
	task end_of_test;
		$display("mismatches %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge clk);
		n_errors++;
		end_of_test;
	end
	initial begin
		repeat (10) @(negedge clk);
		benchRstN = 1'b1;
		@(negedge clk);
		t_regs;
		t_pulse;
		t_key;
		t_forced;
		end_of_test;
	end
endmodule // fibc_flash_isp_boot_control_bench
bind fibc_flash_isp_boot_control fibc_checker chk_u (.clk, .rst_n, .jumpToBootInstr,
	.returnToFlashInstr, .execBootRom, .bootGranted, .flashOpStart, .flashPulse,
	.flashOpBusy, .writeDataOut, .secBit, .massEraseDone, .userClearSec, .forcedBootHv,
	.serialClockPinOe);

/* File: sim/fibc_host_model.sv */
`timescale 1ns/1ns
// ****
// forced boot host
// ****
module fibc_host_model (
	// pins toward the device
	input wire logic clk,
	output logic     hostRstN,
	output logic     forcedBootHv,
	output logic     forcedBootPin,
	output logic     loadClock
);
	initial begin
		hostRstN = 1'b1;
		forcedBootHv = 1'b0;
		forcedBootPin = 1'b0;
		loadClock = 1'b0;
	end
	// load clock stands still unless high voltage is present
	always @(negedge clk) begin
		loadClock <= forcedBootHv & ~loadClock;
	end
	task hv_on;
		@(negedge clk);
		hostRstN = 1'b0;
		repeat (2) @(negedge clk);
		forcedBootHv = 1'b1;
		forcedBootPin = 1'b1;
		repeat (3) @(negedge clk);
		hostRstN = 1'b1;
	endtask
	// caller waits well over three cycles after reset release
	task hv_off;
		forcedBootHv = 1'b0;
		forcedBootPin = 1'b0;
	endtask
endmodule // fibc_host_model
